// file: bench/two_wire_slave_with_user_memory_lock_test.sv
// self-checking bench for the two-wire slave with lockable user memory
// assumes twsl_master as bus master and a pulled-up shared data line
`timescale 1ns/1ps
module two_wire_slave_with_user_memory_lock_test;
  import twsl_pkg::*;
  // arbitrary type code
  localparam logic [3:0] TC = 4'h9;
  localparam int unsigned LOCK = 8000;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic event_in = 1'b0;
  logic scl, sda_low, sda_out, sda_oe, lock_flag, a;
  wire sda = ~(sda_oe | sda_low);
  int fails = 0;
  int checked = 0;
  logic [7:0] d;
  logic [7:0] w[$];
  logic [7:0] e[$];
  logic [7:0] m[$];
  always #5 ref_clk = ~ref_clk;
  twsl_slave #(.TYPE_CODE(TC), .LOCKOUT_CYCLES(LOCK), .FIFO_DEPTH(TWSL_FIFO_DEPTH)) dut_u (.ref_clk(ref_clk),
    .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .event_in(event_in), .user_memory_lock_flag(lock_flag));
  twsl_master m_u (.scl(scl), .sda_low(sda_low), .sda(sda));
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte
  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk_byte(what, {7'h00, exp}, {7'h00, got});
  endtask : chk_bit
  task automatic clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : clk
  task automatic fin(input string s);
    $display("test %s finished", s);
  endtask : fin
  task automatic fill(input int n);
    w = {};
    repeat (n) w.push_back(8'($urandom));
  endtask : fill
  task automatic addr(input logic r, input logic [3:0] tc, input logic [2:0] sel, input logic exp);
    m_u.start();
    m_u.wbyte({tc, sel, r}, a);
    chk_bit("address ack", exp, a);
  endtask : addr
  task automatic wr(input logic [7:0] wa);
    addr(1'b0, TC, TWSL_SELECT, 1'b1);
    m_u.wbyte(wa, a);
    chk_bit("word ack", 1'b1, a);
    foreach (w[i]) begin
      m_u.wbyte(w[i], a);
      chk_bit("data ack", logic'(i < TWSL_FIFO_DEPTH), a);
    end
    m_u.stop();
  endtask : wr
  task automatic rd(input logic [7:0] wa);
    addr(1'b0, TC, TWSL_SELECT, 1'b1);
    m_u.wbyte(wa, a);
    addr(1'b1, TC, TWSL_SELECT, 1'b1);
    foreach (e[i]) begin
      m_u.rbyte(logic'(i < e.size() - 1), d);
      chk_byte("read data", e[i], d);
    end
    chk_bit("released", 1'b0, sda_oe);
    m_u.stop();
    chk_bit("bus free", 1'b1, sda);
  endtask : rd
  task automatic test_done();
    $display("compares %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #500000;
    fails++;
    test_done();
  end
  initial begin
    void'($urandom(32'hC1DB83CE));
    clk(16);
    reset <= 1'b0;
    clk(4);
    chk_bit("lock flag", 1'b0, lock_flag);
    chk_bit("data out level", 1'b0, sda_out);
    fin("reset");
    addr(1'b0, TC, 3'h7, 1'b0);
    m_u.stop();
    repeat (6) begin
      d = 8'($urandom);
      if (d[7:1] == {TC, TWSL_SELECT}) d[4] = ~d[4];
      addr(d[0], d[7:4], d[3:1], 1'b0);
      chk_bit("silent", 1'b0, sda_oe);
      m_u.stop();
    end
    fin("address");
    fill(10);
    wr(TWSL_USER_BASE);
    clk(50);
    e = w;
    m = w;
    rd(TWSL_USER_BASE);
    fin("user memory");
    clk(1);
    event_in <= 1'b1;
    clk(4);
    addr(1'b0, TC, TWSL_SELECT, 1'b0);
    m_u.stop();
    clk(1);
    event_in <= 1'b0;
    clk(4);
    fill(33);
    wr(TWSL_USER_BASE);
    e = '{m[0]};
    rd(TWSL_USER_BASE);
    clk(LOCK);
    e = w[0:9];
    m = e;
    rd(TWSL_USER_BASE);
    fin("lockout");
    w = '{8'hAA};
    wr(TWSL_LOCK_ADDR);
    w = '{8'h55};
    wr(8'h16);
    w = '{8'hAA};
    wr(TWSL_LOCK_ADDR);
    clk(50);
    chk_bit("lock flag", 1'b0, lock_flag);
    wr(TWSL_LOCK_ADDR);
    clk(50);
    chk_bit("lock flag", 1'b1, lock_flag);
    e = '{8'h10};
    rd(TWSL_CTRL_ADDR);
    fill(10);
    wr(TWSL_USER_BASE);
    clk(50);
    e = m;
    rd(TWSL_USER_BASE);
    fin("lock");
    test_done();
  end
endmodule : two_wire_slave_with_user_memory_lock_test

// file: bench/twsl_master.sv
// two-wire bus master model: makes the link clock and drives data low
// assumes a pull-up on the data line; clock stands high outside frames
`timescale 1ns/1ps
module twsl_master (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // quarter of a 125 ns bit period
  localparam realtime Q = 31.25;
  logic busy = 1'b0;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bit_io(input logic b, output logic s);
    scl <= 1'b0;
    #Q sda_low <= ~b;
    #Q scl <= 1'b1;
    #Q s = sda;
    #Q;
  endtask : bit_io
  task automatic start();
    if (busy) begin
      scl <= 1'b0;
      #Q sda_low <= 1'b0;
      #Q scl <= 1'b1;
      #Q;
    end
    sda_low <= 1'b1;
    #(2*Q);
    busy = 1'b1;
  endtask : start
  task automatic stop();
    scl <= 1'b0;
    #Q sda_low <= 1'b1;
    #Q scl <= 1'b1;
    #Q sda_low <= 1'b0;
    #(2*Q);
    busy = 1'b0;
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : wbyte
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask : rbyte
endmodule : twsl_master

// file: hw/twsl_fifo.sv
// first-in first-out buffer with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module twsl_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic push, pop, full, empty;

  always_comb begin
    full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
    empty = (wr_r == rd_r);
    in_ready = !full;
    out_valid = !empty;
    push = in_valid && !full;
    pop = out_ready && !empty;
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    out_data = mem_r[rd_r[AW-1:0]];
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
    end
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data;
    end
  end

endmodule : twsl_fifo

// file: hw/twsl_slave.sv
// two-wire bus slave with ten-byte user memory and a one-way write lock
// assumes scl, sda and event come from pins and are asynchronous to ref_clk
`timescale 1ns/1ps
module twsl_slave import twsl_pkg::*; #(
  parameter logic [3:0] TYPE_CODE = 4'h5, // arbitrary value
  parameter int unsigned LOCKOUT_CYCLES = TWSL_LOCKOUT_CYCLES,
  parameter int unsigned FIFO_DEPTH = TWSL_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic event_in,
  output logic user_memory_lock_flag
);

  function automatic logic is_user(input logic [7:0] a);
    return (a >= TWSL_USER_BASE) && (a < TWSL_USER_END);
  endfunction : is_user

  function automatic logic [3:0] user_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - TWSL_USER_BASE;
    return d[3:0];
  endfunction : user_idx

  // pin synchronisers, then one more stage for edge finding
  logic [2:0] sync1_r, sync2_r, prev_r;
  logic scl_s, sda_s, ev_s, scl_p, sda_p, ev_p;
  logic scl_rise, scl_fall, start_c, stop_c, ev_fall;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sync1_r <= TWSL_SYNC_RESET;
      sync2_r <= TWSL_SYNC_RESET;
      prev_r <= TWSL_SYNC_RESET;
    end else begin
      sync1_r <= {event_in, sda_in, scl_in};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  always_comb begin
    scl_s = sync2_r[0];
    sda_s = sync2_r[1];
    ev_s = sync2_r[2];
    scl_p = prev_r[0];
    sda_p = prev_r[1];
    ev_p = prev_r[2];
    scl_rise = scl_s && !scl_p;
    scl_fall = !scl_s && scl_p;
    start_c = scl_s && scl_p && sda_p && !sda_s;
    stop_c = scl_s && scl_p && !sda_p && sda_s;
    ev_fall = ev_p && !ev_s;
  end

  // bus state machine
  twsl_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt, tx_r, tx_nxt, ptr_r, ptr_nxt, rx_byte, rd_byte;
  logic ack_r, ack_nxt, oe_r, oe_nxt;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [15:0] fifo_in_data, fifo_out_data;
  logic [7:0] mem_r [TWSL_USER_BYTES];
  logic [7:0] mem_nxt [TWSL_USER_BYTES];
  logic lock_r, lock_nxt, armed_r, armed_nxt, mem_we, pop;
  logic [31:0] lock_cnt_r, lock_cnt_nxt;

  always_comb begin
    if (is_user(ptr_r)) begin
      rd_byte = mem_r[user_idx(ptr_r)];
    end else if (ptr_r == TWSL_CTRL_ADDR) begin
      rd_byte = 8'h00;
      rd_byte[TWSL_LOCK_BIT] = lock_r;
    end else begin
      rd_byte = 8'h00;
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    ack_nxt = ack_r;
    oe_nxt = oe_r;
    fifo_in_valid = 1'b0;
    rx_byte = {shift_r[6:0], sda_s};
    fifo_in_data = {ptr_r, rx_byte};
    if (ev_s) begin
      state_nxt = TWSL_IDLE;
      oe_nxt = 1'b0;
    end else if (start_c) begin
      state_nxt = TWSL_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (stop_c) begin
      state_nxt = TWSL_IDLE;
      oe_nxt = 1'b0;
    end else if (scl_rise) begin
      if (cnt_r < 4'h8) begin
        cnt_nxt = cnt_r + 4'h1;
      end
      if (state_r inside {TWSL_ADDR, TWSL_REG, TWSL_WDATA} && cnt_r < 4'h8) begin
        shift_nxt = rx_byte;
        if (cnt_r == 4'h7) begin
          unique case (state_r)
            TWSL_ADDR: ack_nxt = (rx_byte[7:1] == {TYPE_CODE, TWSL_SELECT});
            TWSL_REG: begin
              ack_nxt = 1'b1;
              ptr_nxt = rx_byte;
            end
            default: begin
              ack_nxt = fifo_in_ready;
              fifo_in_valid = fifo_in_ready;
              if (fifo_in_ready) begin
                ptr_nxt = ptr_r + 8'h01;
              end
            end
          endcase
        end
      end
      if (state_r == TWSL_RDATA && cnt_r == 4'h9) begin
        ack_nxt = !sda_s;
      end
    end else if (scl_fall && state_r != TWSL_IDLE && state_r != TWSL_IGNORE) begin
      if (cnt_r == 4'h8) begin
        cnt_nxt = 4'h9;
        oe_nxt = (state_r != TWSL_RDATA) && ack_r;
      end else if (cnt_r == 4'h9) begin
        cnt_nxt = 4'h0;
        oe_nxt = 1'b0;
        unique case (state_r)
          TWSL_ADDR: begin
            if (!ack_r) begin
              state_nxt = TWSL_IGNORE;
            end else if (shift_r[0]) begin
              state_nxt = TWSL_RDATA;
              tx_nxt = rd_byte;
              oe_nxt = !rd_byte[7];
              ptr_nxt = ptr_r + 8'h01;
            end else begin
              state_nxt = TWSL_REG;
            end
          end
          TWSL_REG: state_nxt = TWSL_WDATA;
          TWSL_WDATA: state_nxt = TWSL_WDATA;
          default: begin
            if (ack_r) begin
              tx_nxt = rd_byte;
              oe_nxt = !rd_byte[7];
              ptr_nxt = ptr_r + 8'h01;
            end else begin
              state_nxt = TWSL_IGNORE;
            end
          end
        endcase
      end else if (state_r == TWSL_RDATA && cnt_r != 4'h0) begin
        tx_nxt = {tx_r[6:0], 1'b0};
        oe_nxt = !tx_r[6];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= TWSL_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      ack_r <= ack_nxt;
      oe_r <= oe_nxt;
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe = oe_r;
  assign user_memory_lock_flag = lock_r;

  twsl_fifo #(
    .WIDTH(TWSL_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // nonvolatile side: lockout timer, queued writes, lock flag
  always_comb begin
    lock_cnt_nxt = lock_cnt_r;
    if (ev_fall) begin
      lock_cnt_nxt = 32'(LOCKOUT_CYCLES);
    end else if (lock_cnt_r != 32'h0) begin
      lock_cnt_nxt = lock_cnt_r - 32'h1;
    end
    fifo_out_ready = !ev_s && !ev_fall && lock_cnt_r == 32'h0;
    pop = fifo_out_valid && fifo_out_ready;
    mem_we = pop && is_user(fifo_out_data[15:8]) && !lock_r;
    mem_nxt = mem_r;
    if (mem_we) begin
      mem_nxt[user_idx(fifo_out_data[15:8])] = fifo_out_data[7:0];
    end
    lock_nxt = lock_r;
    armed_nxt = armed_r;
    if (pop) begin
      if (fifo_out_data[15:8] == TWSL_LOCK_ADDR && fifo_out_data[7:0] == TWSL_LOCK_CMD) begin
        armed_nxt = 1'b1;
        lock_nxt = lock_r || armed_r;
      end else begin
        armed_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lock_cnt_r <= 32'h0;
      lock_r <= 1'b0;
      armed_r <= 1'b0;
      for (int i = 0; i < TWSL_USER_BYTES; i++) begin
        mem_r[i] <= TWSL_MEM_RESET;
      end
    end else begin
      lock_cnt_r <= lock_cnt_nxt;
      lock_r <= lock_nxt;
      armed_r <= armed_nxt;
      mem_r <= mem_nxt;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  start_detect_a: assert property (start_c && !ev_s |=> state_r == TWSL_ADDR && cnt_r == 4'h0)
    else $error("start not taken");
  stop_detect_a: assert property (stop_c && !ev_s |=> state_r == TWSL_IDLE && !sda_oe)
    else $error("stop not taken");
  event_silent_a: assert property (ev_s |=> !sda_oe)
    else $error("bus driven during event");
  addr_match_a: assert property (state_r == TWSL_ADDR && scl_rise && cnt_r == 4'h7 && !ev_s && !start_c && !stop_c
    |=> ack_r == ($past(rx_byte[7:1]) == {TYPE_CODE, TWSL_SELECT}))
    else $error("address match wrong");
  ignore_quiet_a: assert property (state_r == TWSL_IGNORE |-> !sda_oe)
    else $error("unaddressed device drives bus");
  lock_sticky_a: assert property (lock_r |=> lock_r)
    else $error("lock flag cleared");
  locked_nowrite_a: assert property (lock_r |-> !mem_we)
    else $error("write while locked");
  lockout_hold_a: assert property (ev_fall |=> !fifo_out_ready [*8])
    else $error("memory written during lockout");
  read_drive_a: assert property (state_r == TWSL_RDATA && cnt_r < 4'h8 |-> sda_oe == !tx_r[7])
    else $error("read bit not driven");
  ack_drive_a: assert property (state_r inside {TWSL_ADDR, TWSL_REG, TWSL_WDATA} && scl_fall && cnt_r == 4'h8
    && ack_r && !ev_s |=> sda_oe && cnt_r == 4'h9)
    else $error("ack not driven");

  write_done_c: cover property (mem_we);
  lock_set_c: cover property (!lock_r ##1 lock_r);
  read_byte_c: cover property (state_r == TWSL_RDATA && scl_fall && cnt_r == 4'h9 && ack_r);
  addr_nack_c: cover property (state_r == TWSL_ADDR ##1 state_r == TWSL_IGNORE);

endmodule : twsl_slave

// file: shared/twsl_pkg.sv
// constants and types of the two-wire slave with lockable user memory
// assumes a single 100 MHz clock domain for all users of the package
package twsl_pkg;

  localparam int unsigned TWSL_CLK_HZ = 100_000_000;
  localparam int unsigned TWSL_LOCKOUT_MS = 500;
  localparam int unsigned TWSL_LOCKOUT_CYCLES = TWSL_LOCKOUT_MS * (TWSL_CLK_HZ / 1000);

  // device select bits high, mid, low
  localparam logic [2:0] TWSL_SELECT = 3'h3;

  localparam logic [7:0] TWSL_CTRL_ADDR = 8'h00;
  localparam logic [7:0] TWSL_USER_BASE = 8'h0C;
  localparam logic [7:0] TWSL_USER_END = 8'h16;
  localparam int unsigned TWSL_USER_BYTES = 10;
  localparam logic [7:0] TWSL_LOCK_ADDR = 8'h1F;
  localparam logic [7:0] TWSL_LOCK_CMD = 8'hAA;
  localparam int unsigned TWSL_LOCK_BIT = 4;
  localparam logic [7:0] TWSL_MEM_RESET = 8'h00;

  localparam logic [2:0] TWSL_SYNC_RESET = 3'h3;
  localparam int unsigned TWSL_FIFO_DEPTH = 32;
  localparam int unsigned TWSL_FIFO_WIDTH = 16;

  typedef enum logic [2:0] {
    TWSL_IDLE,
    TWSL_ADDR,
    TWSL_REG,
    TWSL_WDATA,
    TWSL_RDATA,
    TWSL_IGNORE
  } twsl_state_t;

endpackage : twsl_pkg
